//--- dee_ctrl.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Contract
// [R1] Bulk erase clears whole array, ignores address.
// [R2] Host configures bulk erase, keys, sets start.
// [R3] Start begins cycle; done clears start, flags.
// [R4] Program-only skips auto erase; host erases first.
// [R5] Code 0001xx with erase clear programs one word.
// [R6] Host loads write latch by table write.
// [R7] Table read returns page plus offset word.
// [R8] Visibility window also returns array words.
// [R9] Control 0x4058 means one-word erase, enabled.
// [R10] Control 0x4050 means bulk erase, enabled.
// [R11] Control 0x4004 means one-word program, enabled.
// [R12] Host blocks interrupts around unlock and start.
// [R13] Four and eight word erase use same start.
// [R14] Erase codes decode to eight, four, one, bulk.
// [R15] Erase bit picks erase or write cycle.
// [R16] Host never reads during an active cycle.
// [R17] Start ignored without preceding correct key sequence.
module dee_ctrl #(
    parameter int ERASE_CYCLES = dee_pkg::ERASE_CYC,
    parameter int WRITE_CYCLES = dee_pkg::WRITE_CYC
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire dee_pkg::dee_reg_req_t i_reg,
    output logic [15:0]                o_reg_rdata,
    input  wire dee_pkg::dee_mem_req_t i_mem,
    input  wire logic                  i_tbl_wr,
    input  wire logic [15:0]           i_tbl_wdata,
    output logic [15:0]                o_mem_rdata,
    output logic                       o_busy,
    output logic                       o_irq
);

    logic [15:0] mem_q [dee_pkg::DEPTH];

    dee_pkg::dee_state_t state_q;
    dee_pkg::dee_state_t state_d;
    logic [15:0]         ctl_q;
    logic [7:0]          page_q;
    logic [1:0]          key_q;
    logic [1:0]          status_q;
    logic [1:0]          mask_q;
    logic [15:0]         latch_q;
    logic [8:0]          addr_q;
    logic [8:0]          wptr_q;
    logic [3:0]          left_q;
    logic [31:0]         timer_q;
    logic [15:0]         reg_rdata_q;
    logic [15:0]         mem_rdata_q;
    logic                busy_q;
    logic                irq_q;

    // A word's position in the array: page low bit joined with the even offset.
    function automatic logic [8:0] word_index(input logic [7:0] page, input logic [15:0] offs);
        word_index = {page[0], offs[8:1]};
    endfunction : word_index

    wire logic       wr_ctl     = i_reg.wr && (i_reg.addr == dee_pkg::REG_CONTROL);
    wire logic       wr_key     = i_reg.wr && (i_reg.addr == dee_pkg::REG_KEY);
    wire logic       wr_status  = i_reg.wr && (i_reg.addr == dee_pkg::REG_STATUS);
    wire logic [5:0] op         = ctl_q[5:0];
    wire logic       erase_sel  = ctl_q[dee_pkg::CTL_ERASE_BIT];
    wire logic       want_start = wr_ctl && i_reg.wdata[dee_pkg::CTL_START_BIT]
                                  && ctl_q[dee_pkg::CTL_WREN_BIT]
                                  && state_q == dee_pkg::ST_IDLE;
    wire logic       unlocked   = (key_q == 2'h2);
    wire logic       go         = want_start && unlocked;                   // see [R17]
    wire logic       key_err    = want_start && !unlocked;
    wire logic       is_bulk    = erase_sel && op[5:2] == dee_pkg::OP_BULK_HI;  // see [R14]
    wire logic       is_e8      = erase_sel && op == dee_pkg::OP_ERASE8;    // see [R13]
    wire logic       is_e4      = erase_sel && op == dee_pkg::OP_ERASE4;
    wire logic       is_e1      = erase_sel && op == dee_pkg::OP_ERASE1;    // see [R9]
    wire logic       is_w1      = !erase_sel && op[5:2] == dee_pkg::OP_WRITE_HI; // see [R5] [R11]
    wire logic       valid_op   = is_bulk || is_e8 || is_e4 || is_e1 || is_w1;
    wire logic [8:0] rd_index   = i_mem.is_psv ? i_mem.addr[9:1]
                                               : word_index(page_q, i_mem.addr); // see [R7] [R8]
    wire logic       tick_done  = (timer_q == 32'h0000_0001);
    // The start bit drops only once the whole run is over, erase and program alike.
    wire logic       cycle_end  = (state_q == dee_pkg::ST_WAIT);
    wire logic       pgm_only   = ctl_q[dee_pkg::CTL_PROGRAM_ONLY_BIT_BIT];

    // Next state is chosen from the decoded code; an undecoded code never leaves idle.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dee_pkg::ST_IDLE: begin
                if (go && valid_op) begin                               // see [R15]
                    state_d = (erase_sel || !pgm_only) ? dee_pkg::ST_ERASE
                                                       : dee_pkg::ST_PROG;
                end
            end
            dee_pkg::ST_ERASE: begin
                if (tick_done && left_q == 4'h1) begin
                    state_d = erase_sel ? dee_pkg::ST_WAIT : dee_pkg::ST_PROG;
                end
            end
            dee_pkg::ST_PROG: begin
                if (tick_done) begin
                    state_d = dee_pkg::ST_WAIT;
                end
            end
            dee_pkg::ST_WAIT: state_d = dee_pkg::ST_IDLE;
            default:          state_d = dee_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= dee_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // The key counter only advances on the exact pair, and any other write re-arms it,
    // so a stray access between the keys and the start bit voids the unlock.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            key_q <= 2'h0;
        end else if (wr_key && i_reg.wdata[7:0] == dee_pkg::KEY_FIRST) begin
            key_q <= 2'h1;
        end else if (wr_key && key_q == 2'h1 && i_reg.wdata[7:0] == dee_pkg::KEY_SECOND) begin
            key_q <= 2'h2;
        end else if (i_reg.wr || i_reg.rd) begin
            key_q <= 2'h0;                                              // see [R17]
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= dee_pkg::CTL_RESET;
        end else if (cycle_end) begin
            ctl_q[dee_pkg::CTL_START_BIT] <= 1'b0;                      // see [R3]
        end else if (wr_ctl && state_q == dee_pkg::ST_IDLE) begin
            ctl_q <= (i_reg.wdata & dee_pkg::CTL_WRITE_MASK)
                   | {go && valid_op, 15'h0000};
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            page_q <= 8'h00;
            mask_q <= 2'h0;
        end else if (i_reg.wr && i_reg.addr == dee_pkg::REG_PAGE) begin
            page_q <= i_reg.wdata[7:0];
        end else if (i_reg.wr && i_reg.addr == dee_pkg::REG_MASK) begin
            mask_q <= i_reg.wdata[1:0];
        end
    end

    // Table writes land in the latch and capture the target; the cycle uses both.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            latch_q <= 16'h0000;
            addr_q  <= 9'h000;
        end else if (i_tbl_wr && state_q == dee_pkg::ST_IDLE) begin
            latch_q <= i_tbl_wdata;
            addr_q  <= word_index(page_q, i_mem.addr);
        end
    end

    // Setting a status bit wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            status_q <= 2'h0;
        end else begin
            status_q <= (status_q & ~(wr_status ? i_reg.wdata[1:0] : 2'h0))
                      | {key_err, state_q == dee_pkg::ST_WAIT};         // see [R3]
        end
    end

    // Erase steps one word per timer period; bulk clears every word in one period.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            timer_q <= 32'h0000_0000;
            left_q  <= 4'h0;
            wptr_q  <= 9'h000;
        end else if (state_q == dee_pkg::ST_IDLE && state_d == dee_pkg::ST_ERASE) begin
            timer_q <= 32'(ERASE_CYCLES);
            left_q  <= is_e8 ? 4'h8 : (is_e4 ? 4'h4 : 4'h1);
            wptr_q  <= is_bulk ? 9'h000 : (is_e8 ? {addr_q[8:3], 3'h0}
                     : (is_e4 ? {addr_q[8:2], 2'h0} : addr_q));         // see [R1]
        end else if (state_d == dee_pkg::ST_PROG && state_q != dee_pkg::ST_PROG) begin
            timer_q <= 32'(WRITE_CYCLES);
        end else if (tick_done && state_q == dee_pkg::ST_ERASE) begin
            timer_q <= 32'(ERASE_CYCLES);
            left_q  <= left_q - 4'h1;
            wptr_q  <= wptr_q + 9'h001;
        end else if (timer_q != 32'h0000_0000) begin
            timer_q <= timer_q - 32'h0000_0001;
        end
    end

    // Array contents are not reset; cells are nonvolatile.
    always_ff @(posedge i_core_clk) begin
        if (state_q == dee_pkg::ST_ERASE && tick_done) begin
            if (is_bulk) begin
                for (int i = 0; i < dee_pkg::DEPTH; i++) begin
                    mem_q[i] <= dee_pkg::ERASED_WORD;                   // see [R1] [R10]
                end
            end else begin
                mem_q[wptr_q] <= dee_pkg::ERASED_WORD;
            end
        end else if (state_q == dee_pkg::ST_PROG && tick_done) begin
            mem_q[addr_q] <= mem_q[addr_q] & latch_q;                   // see [R5] [R4]
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_rdata_q <= 16'h0000;
        end else if (i_mem.rd) begin
            mem_rdata_q <= mem_q[rd_index];                             // see [R7] [R8]
        end
    end

    wire logic [15:0] reg_rd_mux =
        (i_reg.addr == dee_pkg::REG_CONTROL) ? ctl_q :
        (i_reg.addr == dee_pkg::REG_PAGE)    ? {8'h00, page_q} :
        (i_reg.addr == dee_pkg::REG_STATUS)  ? {14'h0000, status_q} :
        (i_reg.addr == dee_pkg::REG_MASK)    ? {14'h0000, mask_q} :
        (i_reg.addr == dee_pkg::REG_LATCH)   ? latch_q :
        (i_reg.addr == dee_pkg::REG_ADDR)    ? {7'h00, addr_q} : 16'h0000;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            reg_rdata_q <= 16'h0000;
            busy_q      <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            reg_rdata_q <= i_reg.rd ? reg_rd_mux : 16'h0000;
            busy_q      <= state_d != dee_pkg::ST_IDLE;
            irq_q       <= |(status_q & mask_q);
        end
    end

    assign o_reg_rdata = reg_rdata_q;
    assign o_mem_rdata = mem_rdata_q;
    assign o_busy      = busy_q;
    assign o_irq       = irq_q;

endmodule : dee_ctrl

//--- dee_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module dee_ctrl_bench;
    logic                  i_core_clk = 1'b0;
    logic                  i_rst = 1'b1;
    dee_pkg::dee_reg_req_t reg_req;
    dee_pkg::dee_mem_req_t mem_req;
    logic                  tbl_wr;
    logic [15:0]           tbl_wdata;
    logic [15:0]           reg_rdata;
    logic [15:0]           mem_rdata;
    logic [15:0]           d;
    logic                  busy;
    logic                  irq;
    logic [15:0]           exp_mem [0:16];
    int                    n_fail = 0;
    int                    n_tests = 0;
    always #4 i_core_clk = ~i_core_clk;
    dee_ctrl #(.ERASE_CYCLES(4), .WRITE_CYCLES(4)) DUT (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg(reg_req), .o_reg_rdata(reg_rdata),
        .i_mem(mem_req), .i_tbl_wr(tbl_wr), .i_tbl_wdata(tbl_wdata),
        .o_mem_rdata(mem_rdata), .o_busy(busy), .o_irq(irq));
    dee_host host (
        .i_core_clk(i_core_clk), .i_busy(busy), .i_reg_rdata(reg_rdata),
        .i_mem_rdata(mem_rdata), .o_reg(reg_req), .o_mem(mem_req), .o_tbl_wr(tbl_wr),
        .o_tbl_wdata(tbl_wdata));
    task automatic end_sim();
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk_all();
        for (int i = 0; i < 17; i++) begin
            host.mrd(1'b0, 16'(2 * i), d);
            `CHK(d, exp_mem[i])
        end
    endtask : chk_all
    initial begin
        logic [3:0]  ra [4] = '{4'h0, 4'h3, 4'h4, 4'hF};
        logic [15:0] ctl [4] = '{16'h4058, 16'h4059, 16'h405A, 16'h4050};
        int          idx [4] = '{3, 6, 10, 0};
        int          lo [4] = '{3, 4, 8, 0};
        int          hi [4] = '{3, 7, 15, 16};
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        for (int k = 0; k < 4; k++) begin
            host.rd(ra[k], d);
            `CHK(d, 16'h0000)
        end
        host.put(dee_pkg::REG_MASK, 16'h0001);
        for (int i = 0; i < 17; i++) begin
            exp_mem[i] = 16'hA000 + 16'(i);
            host.tbl(16'(2 * i), exp_mem[i]);
            host.op(16'h4004);
        end
        chk_all();
        `CHK(irq, 1'b1)
        host.rd(dee_pkg::REG_CONTROL, d);
        `CHK(d, 16'h4004)
        host.put(dee_pkg::REG_STATUS, 16'h0001);
        @(negedge i_core_clk);
        `CHK(irq, 1'b0)
        host.mrd(1'b1, 16'h0006, d);
        `CHK(d, exp_mem[3])
        host.put(dee_pkg::REG_PAGE, 16'h0001);
        host.tbl(16'h0002, 16'hBEEF);
        host.op(16'h4004);
        host.mrd(1'b0, 16'h0002, d);
        `CHK(d, 16'hBEEF)
        host.mrd(1'b1, 16'h0202, d);
        `CHK(d, 16'hBEEF)
        host.put(dee_pkg::REG_PAGE, 16'h0000);
        host.tbl(16'h0004, 16'h00FF);
        host.op(16'h5004);
        exp_mem[2] = exp_mem[2] & 16'h00FF;
        for (int k = 0; k < 4; k++) begin
            if (k < 3) host.tbl(16'(2 * idx[k]), 16'h0000);
            host.op(ctl[k]);
            for (int j = lo[k]; j <= hi[k]; j++) exp_mem[j] = 16'hFFFF;
            chk_all();
        end
        host.put(dee_pkg::REG_MASK, 16'h0000);
        host.put(dee_pkg::REG_STATUS, 16'h0003);
        host.tbl(16'h0000, 16'h5A5A);
        host.op(16'h4004);
        @(negedge i_core_clk);
        `CHK(irq, 1'b0)
        host.put(dee_pkg::REG_MASK, 16'h0001);
        @(negedge i_core_clk);
        `CHK(irq, 1'b1)
        host.put(dee_pkg::REG_STATUS, 16'h0003);
        host.put(dee_pkg::REG_CONTROL, 16'hC004);
        repeat (3) @(negedge i_core_clk);
        `CHK(busy, 1'b0)
        host.rd(dee_pkg::REG_STATUS, d);
        `CHK(d, 16'h0002)
        host.put(dee_pkg::REG_STATUS, 16'h0003);
        host.op(16'h4044);
        host.rd(dee_pkg::REG_STATUS, d);
        `CHK(d, 16'h0000)
        host.mrd(1'b0, 16'h0000, d);
        `CHK(d, 16'h5A5A)
        end_sim();
    end
    // A full run takes well under a thousand cycles, so this span only ends a hang.
    initial begin
        repeat (40000) @(posedge i_core_clk);
        n_fail++;
        end_sim();
    end
endmodule : dee_ctrl_bench
bind dee_ctrl dee_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_mon (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
    .i_mem(i_mem), .i_tbl_wr(i_tbl_wr), .i_tbl_wdata(i_tbl_wdata),
    .o_mem_rdata(o_mem_rdata), .o_busy(o_busy), .o_irq(o_irq));

//--- dee_host.sv
`timescale 1ns/1ps
module dee_host (
    input  wire logic             i_core_clk,
    input  wire logic             i_busy,
    input  wire logic [15:0]      i_reg_rdata,
    input  wire logic [15:0]      i_mem_rdata,
    output dee_pkg::dee_reg_req_t o_reg,
    output dee_pkg::dee_mem_req_t o_mem,
    output logic                  o_tbl_wr,
    output logic [15:0]           o_tbl_wdata
);
    initial begin
        o_reg = '0;
        o_mem = '0;
        o_tbl_wr = 1'b0;
        o_tbl_wdata = 16'h0000;
    end
    // The strobe is left standing so that key writes can follow with no gap.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        o_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_core_clk);
    endtask : wr
    task automatic idle();
        o_reg <= '0;
        @(posedge i_core_clk);
    endtask : idle
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        wr(a, d);
        idle();
    endtask : put
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        o_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge i_core_clk);
        o_reg <= '0;
        @(negedge i_core_clk);
        d = i_reg_rdata;
        @(posedge i_core_clk);
    endtask : rd
    task automatic tbl(input logic [15:0] a, input logic [15:0] d);
        o_mem <= '{rd: 1'b0, is_psv: 1'b0, addr: a};
        o_tbl_wr <= 1'b1;
        o_tbl_wdata <= d;
        @(posedge i_core_clk);
        o_tbl_wr <= 1'b0;
        o_tbl_wdata <= ~d;
        @(posedge i_core_clk);
    endtask : tbl
    task automatic mrd(input logic p, input logic [15:0] a, output logic [15:0] d);
        o_mem <= '{rd: 1'b1, is_psv: p, addr: a};
        @(posedge i_core_clk);
        o_mem <= '{rd: 1'b0, is_psv: p, addr: ~a};
        @(negedge i_core_clk);
        d = i_mem_rdata;
        @(posedge i_core_clk);
    endtask : mrd
    task automatic op(input logic [15:0] c);
        wr(dee_pkg::REG_CONTROL, c);
        wr(dee_pkg::REG_KEY, {8'h00, dee_pkg::KEY_FIRST});
        wr(dee_pkg::REG_KEY, {8'h00, dee_pkg::KEY_SECOND});
        wr(dee_pkg::REG_CONTROL, c | 16'h8000);
        idle();
        for (int k = 0; k < 64 && (k < 3 || i_busy); k++) @(posedge i_core_clk);
    endtask : op
endmodule : dee_host

//--- dee_monitor.sv
`timescale 1ns/1ps
module dee_monitor #(
    parameter int ERASE_CYCLES = 4,
    parameter int WRITE_CYCLES = 4
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_rst,
    input wire dee_pkg::dee_reg_req_t i_reg,
    input wire logic [15:0]           o_reg_rdata,
    input wire dee_pkg::dee_mem_req_t i_mem,
    input wire logic                  i_tbl_wr,
    input wire logic [15:0]           i_tbl_wdata,
    input wire logic [15:0]           o_mem_rdata,
    input wire logic                  o_busy,
    input wire logic                  o_irq
);
    // A program erases first unless program-only is set, so an eight-word erase plus a write bounds every run.
    localparam int RUN_MAX = 8 * ERASE_CYCLES + WRITE_CYCLES + 4;
    localparam int RUN_MIN = (ERASE_CYCLES < WRITE_CYCLES) ? ERASE_CYCLES : WRITE_CYCLES;
    wire       ctl_wr = i_reg.wr && (i_reg.addr == dee_pkg::REG_CONTROL);
    wire       key_wr = i_reg.wr && (i_reg.addr == dee_pkg::REG_KEY);
    wire       key2   = key_wr && (i_reg.wdata[7:0] == dee_pkg::KEY_SECOND);
    wire [6:0] op     = i_reg.wdata[6:0];
    wire       legal  = (op == 7'h5A) || (op == 7'h59) || (op == 7'h58)
                     || (op[6:2] == 5'h14) || (op[6:2] == 5'h01);
    wire       go     = ctl_wr && i_reg.wdata[15] && !o_busy;
    logic       wren_q;
    logic [1:0] mask_q;
    int         run_q;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wren_q <= 1'b0;
            mask_q <= 2'h0;
            run_q  <= 0;
        end else begin
            if (ctl_wr && !o_busy) wren_q <= i_reg.wdata[14];
            if (i_reg.wr && (i_reg.addr == dee_pkg::REG_MASK)) mask_q <= i_reg.wdata[1:0];
            run_q <= o_busy ? run_q + 1 : 0;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_unlock;
        key_wr && (i_reg.wdata[7:0] == dee_pkg::KEY_FIRST) ##1 key2;
    endsequence
    AST_START_RUNS: assert property (s_unlock ##1 (go && legal && wren_q) |-> ##[1:2] o_busy)
        else $error("Unlocked legal start did not raise busy.");
    AST_UNDECODED: assert property (s_unlock ##1 (go && !legal) |-> ##1 (!o_busy) [*3])
        else $error("Undecoded operation started a cycle.");
    AST_NEEDS_KEY: assert property (go && !$past(key2) |-> ##1 (!o_busy) [*2])
        else $error("Start without unlock began a cycle.");
    AST_DONE_IRQ: assert property ($fell(o_busy) && mask_q[0] |-> ##[0:2] o_irq)
        else $error("Completion did not raise the interrupt.");
    AST_RUN_MAX: assert property (run_q <= RUN_MAX)
        else $error("Cycle ran longer than allowed.");
    AST_RUN_MIN: assert property ($fell(o_busy) |-> run_q >= RUN_MIN)
        else $error("Cycle ended too early.");
    AST_MEM_HOLD: assert property (!$past(i_mem.rd) |-> $stable(o_mem_rdata))
        else $error("Array read data moved without a read.");
    AST_IRQ_MASKED: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !o_irq)
        else $error("Interrupt high with all sources masked.");
endmodule : dee_monitor

//--- dee_pkg.sv
package dee_pkg;

    // Register indices on the plain register port (word addresses).
    localparam logic [3:0] REG_CONTROL   = 4'h0;
    localparam logic [3:0] REG_KEY       = 4'h1;
    localparam logic [3:0] REG_PAGE      = 4'h2;
    localparam logic [3:0] REG_STATUS    = 4'h3;
    localparam logic [3:0] REG_MASK      = 4'h4;
    localparam logic [3:0] REG_LATCH     = 4'h5;
    localparam logic [3:0] REG_ADDR      = 4'h6;

    // Control field positions.
    localparam int CTL_START_BIT   = 15;
    localparam int CTL_WREN_BIT    = 14;
    localparam int CTL_PROGRAM_ONLY_BIT_BIT = 12;
    localparam int CTL_ERASE_BIT   = 6;
    localparam logic [15:0] CTL_WRITE_MASK = 16'h507F;
    localparam logic [15:0] CTL_RESET      = 16'h0000;

    // Operation codes.
    localparam logic [5:0] OP_ERASE8 = 6'h1A;
    localparam logic [5:0] OP_ERASE4 = 6'h19;
    localparam logic [5:0] OP_ERASE1 = 6'h18;
    localparam logic [3:0] OP_BULK_HI  = 4'h4;
    localparam logic [3:0] OP_WRITE_HI = 4'h1;

    // Unlock key pair.
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Array geometry.
    localparam int ADDR_W = 9;
    localparam int DEPTH  = 512;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Base of the visibility window in the core's data space.
    localparam logic [15:0] PSV_BASE = 16'h8000;

    // Cell timing: printed figures in microseconds, cycles derived at 125 MHz.
    localparam int CLK_MHZ     = 125;
    localparam int T_ERASE_US  = 4000;
    localparam int T_WRITE_US  = 4000;
    localparam int ERASE_CYC   = T_ERASE_US * CLK_MHZ;
    localparam int WRITE_CYC   = T_WRITE_US * CLK_MHZ;

    // Status and mask bits.
    localparam int ST_DONE_BIT = 0;
    localparam int ST_KEYERR_BIT = 1;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_PROG  = 4'b0100,
        ST_WAIT  = 4'b1000
    } dee_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } dee_reg_req_t;

    typedef struct packed {
        logic        rd;
        logic        is_psv;
        logic [15:0] addr;
    } dee_mem_req_t;

endpackage : dee_pkg
